// ---- hw/cir_pkg.sv ----
package cir_pkg;

	// Register word addresses in the system data space
	localparam logic [6:0] CIR_ADDR_CODEC_CTRL = 7'h78;
	localparam logic [6:0] CIR_ADDR_VBUS_MODE = 7'h79;
	localparam logic [6:0] CIR_ADDR_PATH_GAIN = 7'h7A;
	localparam int CIR_NUM_REGS = 3;

	// Reset values
	localparam logic [15:0] CIR_RST_CODEC_CTRL = 16'h0000;
	localparam logic [2:0] CIR_RST_VBUS_MODE = 3'h0;
	localparam logic [15:0] CIR_RST_PATH_GAIN = 16'h0000;

	// Codec control word field positions
	localparam int CIR_CC_RSVD = 15;
	localparam int CIR_CC_PHASE_DIS = 14;
	localparam int CIR_CC_B_TM_LSB = 11;
	localparam int CIR_CC_A_TM_LSB = 8;
	localparam int CIR_CC_HF_MIC = 7;
	localparam int CIR_CC_HS_MIC = 6;
	localparam int CIR_CC_HF_SPK = 5;
	localparam int CIR_CC_HS_EAR = 4;
	localparam int CIR_CC_B_PWR = 3;
	localparam int CIR_CC_DC_ADD = 2;
	localparam int CIR_CC_A_LINE = 1;
	localparam int CIR_CC_A_PWR = 0;
	localparam logic [15:0] CIR_CC_WMASK = 16'h7FFF;

	// Gain word field positions
	localparam int CIR_G_B_DAC_LSB = 12;
	localparam int CIR_G_B_ADC_LSB = 8;
	localparam int CIR_G_A_DAC_LSB = 4;
	localparam int CIR_G_A_ADC_LSB = 0;
	localparam int CIR_DAC_GAIN_MIN_DB = -13;
	localparam int CIR_ADC_GAIN_MIN_DB = 9;

	typedef enum logic [2:0] {
		CIR_TM_NORMAL = 3'h0,
		CIR_TM_1B_ANALOG = 3'h1,
		CIR_TM_1B_DIGITAL = 3'h2,
		CIR_TM_1B_LOOP = 3'h3,
		CIR_TM_4FS_CODEC = 3'h4,
		CIR_TM_4FS_PROC = 3'h5,
		CIR_TM_4FS_LOOP = 3'h6,
		CIR_TM_PCM_PROBE = 3'h7
	} cir_testmode_e;

	typedef enum logic [2:0] {
		CIR_VB_INACTIVE = 3'h0,
		CIR_VB_UNUSED = 3'h1,
		CIR_VB_256K = 3'h2,
		CIR_VB_512K = 3'h3,
		CIR_VB_768K = 3'h4,
		CIR_VB_1024K = 3'h5,
		CIR_VB_2048K_UNDBL = 3'h6,
		CIR_VB_2048K = 3'h7
	} cir_vbmode_e;

	// Register access request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [6:0] addr;
		logic [1:0] be;
		logic [15:0] wdata;
	} cir_req_s;

	// Per-codec controls
	typedef struct packed {
		logic power_on;
		cir_testmode_e testmode;
		logic [3:0] dac_gain;
		logic [3:0] adc_gain;
	} cir_codec_s;

	// Voice-bus setup
	typedef struct packed {
		logic active;
		logic [5:0] slots;
		logic [11:0] rate_kbps;
		logic clk_doubled;
	} cir_vbus_s;

endpackage

// ---- hw/cir_regfile.sv ----
`timescale 1ns/10ps
module cir_regfile
	import cir_pkg::*;
#(
	parameter int WIDTH = 16,
	parameter int DEPTH = 3
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_nrst,
	// Write port
	input wire logic i_we,
	input wire logic [1:0] i_widx,
	input wire logic [WIDTH-1:0] i_wdata,
	input wire logic [WIDTH-1:0] i_wmask,
	// Read port
	input wire logic [1:0] i_ridx,
	output logic [WIDTH-1:0] o_rdata,
	// Full contents
	output logic [DEPTH*WIDTH-1:0] o_words
);

	// Two-bit indices serve at most four words
	if (DEPTH < 1 || DEPTH > 4 || WIDTH < 1) begin : g_size_bad
		$error("cir_regfile: unsupported size");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];

	// Storage, all zero after reset
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
		end else if (i_we && (32'(i_widx) < DEPTH)) begin
			mem_q[i_widx] <= (mem_q[i_widx] & ~i_wmask) | (i_wdata & i_wmask);
		end
	end

	// Registered read data
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			o_rdata <= '0;
		end else if (32'(i_ridx) < DEPTH) begin
			o_rdata <= mem_q[i_ridx];
		end else begin
			o_rdata <= '0;
		end
	end

	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			o_words[i*WIDTH +: WIDTH] = mem_q[i];
		end
	end

endmodule

// ---- hw/cir_ctrl_regs.sv ----
`timescale 1ns/10ps
module cir_ctrl_regs
	import cir_pkg::*;
(
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_nrst,
	// External serial-bus host port
	input wire cir_req_s i_ext_req,
	output logic [15:0] o_ext_rdata,
	output logic o_ext_rvalid,
	output logic o_ext_hit,
	// Internal system bus port
	input wire cir_req_s i_int_req,
	output logic [15:0] o_int_rdata,
	output logic o_int_rvalid,
	output logic o_int_hit,
	// Codec controls
	output cir_codec_s o_codec_a,
	output cir_codec_s o_codec_b,
	output logic o_phase_corr_disable,
	output logic o_handsfree_mic_supply_on,
	output logic o_handset_mic_supply_on,
	output logic o_handsfree_speaker_enable,
	output logic o_handset_earpiece_enable,
	output logic o_mic_amp_dc_offset_add,
	output logic o_codec_a_line_out_enable,
	// Gain in dB, signed
	output logic signed [5:0] o_codec_a_dac_db,
	output logic signed [5:0] o_codec_a_adc_db,
	output logic signed [5:0] o_codec_b_dac_db,
	output logic signed [5:0] o_codec_b_adc_db,
	// Voice bus setup
	output cir_vbus_s o_vbus
);

	function automatic logic [1:0] addr_idx(input logic [6:0] a);
		case (a)
			CIR_ADDR_CODEC_CTRL: addr_idx = 2'd0;
			CIR_ADDR_VBUS_MODE: addr_idx = 2'd1;
			CIR_ADDR_PATH_GAIN: addr_idx = 2'd2;
			default: addr_idx = 2'd3;
		endcase
	endfunction

	// Byte enables to bit mask, unimplemented bits masked off
	function automatic logic [15:0] wr_mask(input logic [1:0] idx, input logic [1:0] be);
		logic [15:0] m;
		m = {{8{be[1]}}, {8{be[0]}}};
		case (idx)
			2'd0: wr_mask = m & CIR_CC_WMASK;
			2'd1: wr_mask = m & 16'h0007;
			2'd2: wr_mask = m;
			default: wr_mask = 16'h0000;
		endcase
	endfunction

	function automatic logic signed [5:0] dac_db(input logic [3:0] c);
		dac_db = 6'(CIR_DAC_GAIN_MIN_DB) + $signed({2'b00, c});
	endfunction

	function automatic logic signed [5:0] adc_db(input logic [3:0] c);
		adc_db = 6'(CIR_ADC_GAIN_MIN_DB) + $signed({2'b00, c});
	endfunction

	logic [1:0] ext_idx;
	logic [1:0] int_idx;
	logic ext_wr_ok;
	logic we;
	logic [1:0] widx;
	logic [15:0] wdata;
	logic [15:0] wmask;
	logic [1:0] ridx;
	logic [15:0] rdata;
	logic [47:0] words;
	logic [15:0] cc;
	logic [2:0] vbm;
	logic [15:0] gain;
	logic ext_rd_q;
	logic int_rd_q;

	assign ext_idx = addr_idx(i_ext_req.addr);
	assign int_idx = addr_idx(i_int_req.addr);
	assign ext_wr_ok = i_ext_req.wr && ext_idx != 2'd3;

	// Single write port, external host first
	always_comb begin
		we = 1'b0;
		widx = 2'd3;
		wdata = 16'h0000;
		wmask = 16'h0000;
		if (ext_wr_ok) begin
			we = 1'b1;
			widx = ext_idx;
			wdata = i_ext_req.wdata;
			wmask = wr_mask(ext_idx, i_ext_req.be);
		end else if (i_int_req.wr && int_idx != 2'd3) begin
			we = 1'b1;
			widx = int_idx;
			wdata = i_int_req.wdata;
			wmask = wr_mask(int_idx, i_int_req.be);
		end
	end

	// Read port also favours the external host
	assign ridx = i_ext_req.rd ? ext_idx : int_idx;

	cir_regfile #(
		.WIDTH(16),
		.DEPTH(CIR_NUM_REGS)
	) u_regs (
		.i_mclk(i_mclk),
		.i_nrst(i_nrst),
		.i_we(we),
		.i_widx(widx),
		.i_wdata(wdata),
		.i_wmask(wmask),
		.i_ridx(ridx),
		.o_rdata(rdata),
		.o_words(words)
	);

	assign cc = words[15:0];
	assign vbm = words[18:16];
	assign gain = words[47:32];

	// Read strobes, one cycle after the request
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			ext_rd_q <= 1'b0;
			int_rd_q <= 1'b0;
		end else begin
			ext_rd_q <= i_ext_req.rd;
			int_rd_q <= i_int_req.rd && !i_ext_req.rd;
		end
	end

	// Hit flags, one cycle after the request
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			o_ext_hit <= 1'b0;
			o_int_hit <= 1'b0;
		end else begin
			o_ext_hit <= (i_ext_req.rd || i_ext_req.wr) && ext_idx != 2'd3;
			o_int_hit <= ((i_int_req.rd && !i_ext_req.rd) || (i_int_req.wr && !ext_wr_ok)) && int_idx != 2'd3;
		end
	end

	// Read data, two cycles after the request; whole word returned, byte enables ignored
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			o_ext_rdata <= 16'h0000;
			o_int_rdata <= 16'h0000;
			o_ext_rvalid <= 1'b0;
			o_int_rvalid <= 1'b0;
		end else begin
			o_ext_rvalid <= ext_rd_q;
			o_int_rvalid <= int_rd_q;
			if (ext_rd_q) begin
				o_ext_rdata <= rdata;
			end
			if (int_rd_q) begin
				o_int_rdata <= rdata;
			end
		end
	end

	// Codec control word decode
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			o_phase_corr_disable <= 1'b0;
			o_handsfree_mic_supply_on <= 1'b0;
			o_handset_mic_supply_on <= 1'b0;
			o_handsfree_speaker_enable <= 1'b0;
			o_handset_earpiece_enable <= 1'b0;
			o_mic_amp_dc_offset_add <= 1'b0;
			o_codec_a_line_out_enable <= 1'b0;
		end else begin
			o_phase_corr_disable <= cc[CIR_CC_PHASE_DIS];
			o_handsfree_mic_supply_on <= cc[CIR_CC_HF_MIC];
			o_handset_mic_supply_on <= cc[CIR_CC_HS_MIC];
			o_handsfree_speaker_enable <= cc[CIR_CC_HF_SPK];
			o_handset_earpiece_enable <= cc[CIR_CC_HS_EAR];
			o_mic_amp_dc_offset_add <= cc[CIR_CC_DC_ADD];
			o_codec_a_line_out_enable <= cc[CIR_CC_A_LINE];
		end
	end

	// Per-codec power, test mode and gain codes; reset state zero
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			o_codec_a <= '0;
			o_codec_b <= '0;
		end else begin
			o_codec_a.power_on <= cc[CIR_CC_A_PWR];
			o_codec_b.power_on <= cc[CIR_CC_B_PWR];
			o_codec_a.testmode <= cir_testmode_e'(cc[CIR_CC_A_TM_LSB +: 3]);
			o_codec_b.testmode <= cir_testmode_e'(cc[CIR_CC_B_TM_LSB +: 3]);
			o_codec_a.dac_gain <= gain[CIR_G_A_DAC_LSB +: 4];
			o_codec_a.adc_gain <= gain[CIR_G_A_ADC_LSB +: 4];
			o_codec_b.dac_gain <= gain[CIR_G_B_DAC_LSB +: 4];
			o_codec_b.adc_gain <= gain[CIR_G_B_ADC_LSB +: 4];
		end
	end

	// Gain in dB
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			o_codec_a_dac_db <= 6'(CIR_DAC_GAIN_MIN_DB);
			o_codec_b_dac_db <= 6'(CIR_DAC_GAIN_MIN_DB);
			o_codec_a_adc_db <= 6'(CIR_ADC_GAIN_MIN_DB);
			o_codec_b_adc_db <= 6'(CIR_ADC_GAIN_MIN_DB);
		end else begin
			o_codec_a_dac_db <= dac_db(gain[CIR_G_A_DAC_LSB +: 4]);
			o_codec_b_dac_db <= dac_db(gain[CIR_G_B_DAC_LSB +: 4]);
			o_codec_a_adc_db <= adc_db(gain[CIR_G_A_ADC_LSB +: 4]);
			o_codec_b_adc_db <= adc_db(gain[CIR_G_B_ADC_LSB +: 4]);
		end
	end

	// Voice bus mode decode
	always_ff @(posedge i_mclk) begin
		if (!i_nrst) begin
			o_vbus <= '0;
		end else begin
			o_vbus.active <= 1'b1;
			o_vbus.clk_doubled <= 1'b1;
			case (cir_vbmode_e'(vbm))
				CIR_VB_256K: begin
					o_vbus.slots <= 6'd4;
					o_vbus.rate_kbps <= 12'd256;
				end
				CIR_VB_512K: begin
					o_vbus.slots <= 6'd8;
					o_vbus.rate_kbps <= 12'd512;
				end
				CIR_VB_768K: begin
					o_vbus.slots <= 6'd12;
					o_vbus.rate_kbps <= 12'd768;
				end
				CIR_VB_1024K: begin
					o_vbus.slots <= 6'd16;
					o_vbus.rate_kbps <= 12'd1024;
				end
				CIR_VB_2048K: begin
					o_vbus.slots <= 6'd32;
					o_vbus.rate_kbps <= 12'd2048;
				end
				CIR_VB_2048K_UNDBL: begin
					o_vbus.slots <= 6'd32;
					o_vbus.rate_kbps <= 12'd2048;
					o_vbus.clk_doubled <= 1'b0;
				end
				default: begin
					o_vbus.active <= 1'b0;
					o_vbus.slots <= 6'd0;
					o_vbus.rate_kbps <= 12'd0;
					o_vbus.clk_doubled <= 1'b0;
				end
			endcase
		end
	end

endmodule

// ---- verif/cir_host_model.sv ----
`timescale 1ns/10ps
module cir_host_model
	import cir_pkg::*;
(
	// Clock
	input wire logic i_mclk,
	// Request and answer
	output cir_req_s o_req,
	input wire logic [15:0] i_rdata,
	input wire logic i_rvalid
);
	initial o_req = '0;
	// One-cycle byte or word write
	task automatic wr(input logic [6:0] a, input logic [1:0] be, input logic [15:0] d);
		@(posedge i_mclk);
		o_req <= '{1'b1, 1'b0, a, be, d};
		@(posedge i_mclk);
		o_req <= '{1'b0, 1'b0, a, be, ~d};
	endtask
	// Word read, bounded wait for valid
	task automatic rd(input logic [6:0] a, output logic [15:0] d, output logic ok);
		@(posedge i_mclk);
		o_req <= '{1'b0, 1'b1, a, 2'h3, 16'h0000};
		@(posedge i_mclk);
		o_req <= '{1'b0, 1'b0, a, 2'h3, 16'hFFFF};
		ok = 1'b0;
		d = 16'h0000;
		for (int n = 0; n < 4 && !ok; n++) begin
			@(posedge i_mclk);
			#1;
			ok = i_rvalid;
			d = i_rdata;
		end
	endtask
endmodule

// ---- verif/cir_ctrl_regs_chk.sv ----
`timescale 1ns/10ps
module cir_ctrl_regs_chk
	import cir_pkg::*;
(
	// Clock, reset, host port
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire cir_req_s i_ext_req,
	input wire logic [15:0] o_ext_rdata,
	input wire logic o_ext_rvalid,
	input wire logic o_ext_hit,
	// Controls
	input wire cir_codec_s o_codec_a,
	input wire cir_codec_s o_codec_b,
	input wire logic o_phase_corr_disable,
	input wire logic signed [5:0] o_codec_a_dac_db,
	input wire logic signed [5:0] o_codec_b_adc_db,
	input wire cir_vbus_s o_vbus
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);
	logic cc_w, vb_w, map;
	logic [15:0] w1_q, w2_q;
	logic [1:0] rd_q;
	assign cc_w = i_ext_req.wr && i_ext_req.addr == 7'h78 && i_ext_req.be == 2'h3;
	assign vb_w = i_ext_req.wr && i_ext_req.addr == 7'h79 && i_ext_req.be[0];
	assign map = i_ext_req.addr >= 7'h78 && i_ext_req.addr <= 7'h7A;
	// Write data and read delay line
	always_ff @(posedge i_mclk) begin
		w1_q <= i_ext_req.wdata;
		w2_q <= w1_q;
		rd_q <= {rd_q[0], i_nrst && i_ext_req.rd && i_ext_req.addr == 7'h78};
	end
	phase_dis_a: assert property (cc_w |-> ##2 o_phase_corr_disable == w2_q[14])
		else $error("phase");
	test_mode_a: assert property (cc_w |-> ##2 {o_codec_b.testmode, o_codec_a.testmode} == w2_q[13:8])
		else $error("test mode");
	power_on_a: assert property (cc_w |-> ##2 o_codec_b.power_on == w2_q[3]
		&& o_codec_a.power_on == w2_q[0])
		else $error("power");
	dac_db_a: assert property (o_codec_a_dac_db == $signed({2'b00, o_codec_a.dac_gain}) - 6'sd13)
		else $error("dac db");
	adc_db_a: assert property (o_codec_b_adc_db == $signed({2'b00, o_codec_b.adc_gain}) + 6'sd9)
		else $error("adc db");
	vb_rate_a: assert property (o_vbus.active |-> o_vbus.rate_kbps == {o_vbus.slots, 6'h00})
		else $error("vbus rate");
	vb_mode_a: assert property (vb_w |-> ##2 o_vbus.active == (w2_q[2:1] != 2'h0)
		&& o_vbus.clk_doubled == (w2_q[2:1] != 2'h0 && w2_q[2:0] != 3'h6))
		else $error("vbus mode");
	rd_rsvd_a: assert property (rd_q[1] |-> o_ext_rvalid && !o_ext_rdata[15])
		else $error("read bit 15");
	ext_hit_a: assert property ((i_ext_req.wr || i_ext_req.rd) |=> o_ext_hit == $past(map))
		else $error("hit");
	rst_zero_a: assert property (disable iff (1'b0) !i_nrst
		|=> o_codec_a == '0 && o_codec_b == '0)
		else $error("reset");
	cover property (o_ext_rvalid);
	cover property (cc_w);
	cover property (o_vbus.active && !o_vbus.clk_doubled);
endmodule

// ---- verif/cir_ctrl_regs_tb.sv ----
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module cir_ctrl_regs_tb;
	import cir_pkg::*;
	logic i_mclk, i_nrst, ext_rv, int_rv, pcd, hfm, hsm, hfs, hse, dca, alo;
	cir_req_s ext_req, int_req;
	logic [15:0] ext_rd, int_rd;
	cir_codec_s ca, cb;
	logic signed [5:0] adac, aadc, bdac, badc;
	cir_vbus_s vb;
	logic [14:0] ccv;
	logic ext_hit, int_hit;
	int failures = 0;
	int tests_run = 0;
	assign ccv = {pcd, cb.testmode, ca.testmode, hfm, hsm, hfs, hse, cb.power_on, dca, alo, ca.power_on};
	cir_ctrl_regs dut_u (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_ext_req(ext_req), .o_ext_rdata(ext_rd),
		.o_ext_rvalid(ext_rv), .o_ext_hit(ext_hit), .i_int_req(int_req), .o_int_rdata(int_rd), .o_int_rvalid(int_rv),
		.o_int_hit(int_hit), .o_codec_a(ca), .o_codec_b(cb), .o_phase_corr_disable(pcd),
		.o_handsfree_mic_supply_on(hfm),
		.o_handset_mic_supply_on(hsm), .o_handsfree_speaker_enable(hfs), .o_handset_earpiece_enable(hse),
		.o_mic_amp_dc_offset_add(dca), .o_codec_a_line_out_enable(alo), .o_codec_a_dac_db(adac),
		.o_codec_a_adc_db(aadc), .o_codec_b_dac_db(bdac), .o_codec_b_adc_db(badc), .o_vbus(vb));
	cir_host_model h_ext (.i_mclk(i_mclk), .o_req(ext_req), .i_rdata(ext_rd), .i_rvalid(ext_rv));
	cir_host_model h_int (.i_mclk(i_mclk), .o_req(int_req), .i_rdata(int_rd), .i_rvalid(int_rv));
	initial begin
		i_mclk = 1'b0;
		forever #2.5 i_mclk = ~i_mclk;
	end
	task automatic stop_test;
		$display("failures=%0d tests_run=%0d", failures, tests_run);
		if (failures == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic settle;
		repeat (3) @(posedge i_mclk);
		#1;
	endtask
	task automatic wx(input logic [6:0] a, input logic [1:0] be, input logic [15:0] d);
		h_ext.wr(a, be, d);
		settle();
	endtask
	task automatic rchk(input logic [6:0] a, input logic [15:0] e);
		logic [15:0] d;
		logic ok;
		h_ext.rd(a, d, ok);
		if (ok !== 1'b1) begin
			failures++;
			stop_test();
		end
		`CHK("rdata", e, d)
	endtask
	task automatic t_cc;
		wx(7'h78, 2'h3, 16'hFFFF);
		`CHK("cc", 15'h7FFF, ccv)
		rchk(7'h78, 16'h7FFF);
		for (int k = 0; k < 8; k++) begin
			wx(7'h78, 2'h3, {2'b00, 3'(k), 3'(7 - k), 8'h00});
			`CHK("tm", {3'(k), 3'(7 - k)}, {cb.testmode, ca.testmode})
		end
		wx(7'h78, 2'h1, 16'hFF09);
		`CHK("cc", 15'h3809, ccv)
		rchk(7'h78, 16'h3809);
	endtask
	task automatic t_vbus;
		int sl[8] = '{0, 0, 4, 8, 12, 16, 32, 32};
		for (int m = 0; m < 8; m++) begin
			wx(7'h79, 2'h3, {13'h1FFF, 3'(m)});
			rchk(7'h79, {13'h0000, 3'(m)});
			`CHK("vb_act", 1'(m > 1), vb.active)
			if (m > 1) begin
				`CHK("vb_slots", 6'(sl[m]), vb.slots)
				`CHK("vb_rate", 12'(sl[m] * 64), vb.rate_kbps)
				`CHK("vb_dbl", 1'(m != 6), vb.clk_doubled)
			end
		end
	endtask
	task automatic t_gain;
		logic [15:0] d;
		logic ok;
		for (int c = 0; c < 16; c++) begin
			h_int.wr(7'h7A, 2'h2, {4'(c), ~4'(c), 8'hA5});
			#1;
			`CHK("int_hit", 1'b1, int_hit)
			h_int.wr(7'h7A, 2'h1, {8'h5A, ~4'(c), 4'(c)});
			settle();
			`CHK("b_dac", 6'(c - 13), bdac)
			`CHK("b_adc", 6'(24 - c), badc)
			`CHK("a_dac", 6'(2 - c), adac)
			`CHK("a_adc", 6'(c + 9), aadc)
		end
		h_int.rd(7'h7A, d, ok);
		`CHK("int_ok", 1'b1, ok)
		`CHK("int_rd", 16'hF00F, d)
	endtask
	task automatic t_misc;
		wx(7'h7B, 2'h3, 16'hFFFF);
		rchk(7'h7B, 16'h0000);
		rchk(7'h78, 16'h3809);
		fork
			h_ext.wr(7'h78, 2'h3, 16'h0005);
			h_int.wr(7'h78, 2'h3, 16'h000A);
			begin
				repeat (2) @(posedge i_mclk);
				#1;
				`CHK("ext_hit", 1'b1, ext_hit)
				`CHK("int_hit", 1'b0, int_hit)
			end
		join
		settle();
		rchk(7'h78, 16'h0005);
	endtask
	task automatic t_rst;
		@(posedge i_mclk);
		i_nrst <= 1'b0;
		repeat (2) @(posedge i_mclk);
		i_nrst <= 1'b1;
		#1;
		`CHK("cc", 15'h0000, ccv)
		`CHK("vb_act", 1'b0, vb.active)
		`CHK("a_dac", -6'sd13, adac)
		`CHK("b_adc", 6'sd9, badc)
		rchk(7'h78, 16'h0000);
		rchk(7'h79, 16'h0000);
		rchk(7'h7A, 16'h0000);
	endtask
	initial begin
		i_nrst = 1'b0;
		repeat (16) @(posedge i_mclk);
		i_nrst <= 1'b1;
		rchk(7'h7A, 16'h0000);
		t_cc();
		t_vbus();
		t_gain();
		t_misc();
		t_rst();
		stop_test();
	end
endmodule
bind cir_ctrl_regs cir_ctrl_regs_chk chk_u (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_ext_req(i_ext_req),
	.o_ext_rdata(o_ext_rdata), .o_ext_rvalid(o_ext_rvalid), .o_ext_hit(o_ext_hit), .o_codec_a(o_codec_a),
	.o_codec_b(o_codec_b), .o_phase_corr_disable(o_phase_corr_disable), .o_codec_a_dac_db(o_codec_a_dac_db),
	.o_codec_b_adc_db(o_codec_b_adc_db), .o_vbus(o_vbus));
